// ---- hw/hbx_ctrl.v ----
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "hbx_defs.vh"
module hbx_ctrl #(
	parameter [7:0] ACC_CYC = `HBX_T_ACC_CYC,
	parameter [7:0] WR_CYC = `HBX_T_WR_CYC
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// exchanger control pins
	output reg xchg_dir,
	output reg xchg_path,
	output reg upper_byte_out_en_n,
	output reg lower_byte_out_en_n,
	output wire even_read_latch_enable,
	output wire odd_read_latch_enable,
	output wire even_write_latch_enable,
	output wire odd_write_latch_enable,
	// memory column strobe
	output reg col_strobe_n,
	// processor data port
	input wire [15:0] x_in,
	output reg [15:0] x_out,
	output reg x_oe
);

	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_OPEN = 5'b00010;
	localparam [4:0] S_OUTE = 5'b00100;
	localparam [4:0] S_OUTO = 5'b01000;
	localparam [4:0] S_WR = 5'b10000;

	function hit;
		input [11:0] a;
		input [11:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// register state

	reg [4:0] state_r;
	reg [4:0] state_nxt;
	reg [7:0] cnt_r;
	reg [7:0] cnt_nxt;
	reg pair_r;
	reg pair_nxt;
	reg [1:0] op_r;
	reg path_sel_r;
	reg ub_r;
	reg lb_r;
	reg [15:0] wdata_r;
	reg done_r;
	reg latch_en_r;
	reg cap_we;
	reg [1:0] cap_idx;
	reg done_set;
	reg [1:0] op_n;
	reg path_n;
	reg ub_n;
	reg lb_n;
	reg dir_nxt;
	reg path_nxt;
	reg uoe_nxt;
	reg loe_nxt;
	reg latch_nxt;
	reg cas_nxt;
	reg xoe_nxt;
	reg [31:0] rdata_mux;
	reg addr_hit;

	wire wr_stb;
	wire [15:0] mem_rdata;
	wire busy = ~state_r[0];
	wire ctrl_wr = wr_stb & hit(paddr, `HBX_ADDR_CTRL);
	wire start = ctrl_wr & pwdata[`HBX_CTRL_START] & ~busy;
	wire [1:0] op_w = pwdata[`HBX_CTRL_OP_HI:`HBX_CTRL_OP_LO];
	wire done_clr = wr_stb & hit(paddr, `HBX_ADDR_STATUS) & pwdata[`HBX_STAT_DONE];
	wire rdata_hit = (paddr >= `HBX_ADDR_RDATA0) & (paddr <= `HBX_ADDR_RDATA3) & (paddr[1:0] == 2'b00);

	////////////////////////////////////////////////////////////////////////////
	// bus slave

	always @* begin
		addr_hit = 1'b1;
		rdata_mux = 32'h0000_0000;
		if (hit(paddr, `HBX_ADDR_CTRL)) begin
			rdata_mux[`HBX_CTRL_OP_HI:`HBX_CTRL_OP_LO] = op_r;
			rdata_mux[`HBX_CTRL_PATH] = path_sel_r;
			rdata_mux[`HBX_CTRL_UB] = ub_r;
			rdata_mux[`HBX_CTRL_LB] = lb_r;
		end else if (hit(paddr, `HBX_ADDR_STATUS)) begin
			rdata_mux[`HBX_STAT_BUSY] = busy;
			rdata_mux[`HBX_STAT_DONE] = done_r;
		end else if (hit(paddr, `HBX_ADDR_WDATA)) begin
			rdata_mux[15:0] = wdata_r;
		end else if (rdata_hit) begin
			rdata_mux[15:0] = mem_rdata;
		end else begin
			addr_hit = 1'b0;
		end
	end

	hbx_apb_if u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.rdata_in(rdata_mux),
		.hit_in(addr_hit),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.wr_stb(wr_stb)
	);

	// captured words, read back over the bus
	hbx_word_mem #(
		.W(16),
		.AW(2)
	) u_mem (
		.pclk(pclk),
		.we(cap_we),
		.waddr(cap_idx),
		.wdata(x_in),
		.raddr(paddr[3:2]),
		.rdata_r(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 8'h01;
		pair_nxt = pair_r;
		cap_we = 1'b0;
		cap_idx = 2'b00;
		done_set = 1'b0;
		case (state_r)
			S_IDLE: begin
				cnt_nxt = 8'h00;
				pair_nxt = 1'b0;
				if (start) begin
					// unknown op codes are ignored
					if (op_w == `HBX_OP_SINGLE || op_w == `HBX_OP_BURST) begin
						state_nxt = S_OPEN;
					end else if (op_w == `HBX_OP_WRITE) begin
						state_nxt = S_WR;
					end
				end
			end
			S_OPEN: begin
				if (cnt_r == ACC_CYC - 8'h01) begin
					cnt_nxt = 8'h00;
					if (op_r == `HBX_OP_SINGLE) begin
						// flow-through: sample at end of the open window
						cap_we = 1'b1;
						done_set = 1'b1;
						state_nxt = S_IDLE;
					end else begin
						state_nxt = S_OUTE;
					end
				end
			end
			S_OUTE: begin
				cap_we = 1'b1;
				cap_idx = {pair_r, 1'b0};
				cnt_nxt = 8'h00;
				state_nxt = S_OUTO;
			end
			S_OUTO: begin
				cap_we = 1'b1;
				cap_idx = {pair_r, 1'b1};
				cnt_nxt = 8'h00;
				if (pair_r) begin
					done_set = 1'b1;
					state_nxt = S_IDLE;
				end else begin
					pair_nxt = 1'b1;
					state_nxt = S_OPEN;
				end
			end
			S_WR: begin
				if (cnt_r == WR_CYC - 8'h01) begin
					cnt_nxt = 8'h00;
					done_set = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_IDLE;
				cnt_nxt = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// pin levels for the coming cycle

	always @* begin
		op_n = start ? op_w : op_r;
		path_n = start ? pwdata[`HBX_CTRL_PATH] : path_sel_r;
		ub_n = start ? pwdata[`HBX_CTRL_UB] : ub_r;
		lb_n = start ? pwdata[`HBX_CTRL_LB] : lb_r;
		dir_nxt = 1'b0;
		path_nxt = xchg_path;
		uoe_nxt = 1'b1;
		loe_nxt = 1'b1;
		latch_nxt = 1'b1;
		cas_nxt = 1'b1;
		xoe_nxt = 1'b0;
		case (state_nxt)
			S_IDLE: begin
				latch_nxt = 1'b1;
			end
			S_OPEN: begin
				dir_nxt = 1'b0;
				latch_nxt = 1'b1;
				cas_nxt = 1'b0;
				if (op_n == `HBX_OP_SINGLE) begin
					path_nxt = path_n;
					uoe_nxt = ~ub_n;
					loe_nxt = ~lb_n;
				end else begin
					// both banks fetched at once; processor port stays quiet
					path_nxt = 1'b1;
				end
			end
			S_OUTE: begin
				latch_nxt = 1'b0;
				path_nxt = 1'b1;
				uoe_nxt = ~ub_n;
				loe_nxt = ~lb_n;
				cas_nxt = 1'b1;
			end
			S_OUTO: begin
				latch_nxt = 1'b0;
				path_nxt = 1'b0;
				uoe_nxt = ~ub_n;
				loe_nxt = ~lb_n;
				// reassert for the second pair only
				cas_nxt = pair_r;
			end
			S_WR: begin
				dir_nxt = 1'b1;
				path_nxt = path_n;
				uoe_nxt = ~ub_n;
				loe_nxt = ~lb_n;
				cas_nxt = 1'b0;
				xoe_nxt = 1'b1;
			end
			default: begin
				latch_nxt = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// flops

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_IDLE;
			cnt_r <= 8'h00;
			pair_r <= 1'b0;
			op_r <= `HBX_OP_SINGLE;
			path_sel_r <= 1'b0;
			ub_r <= 1'b1;
			lb_r <= 1'b1;
			wdata_r <= 16'h0000;
			done_r <= 1'b0;
			xchg_dir <= 1'b0;
			xchg_path <= 1'b0;
			upper_byte_out_en_n <= 1'b1;
			lower_byte_out_en_n <= 1'b1;
			latch_en_r <= 1'b1;
			col_strobe_n <= 1'b1;
			x_out <= 16'h0000;
			x_oe <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			pair_r <= pair_nxt;
			if (ctrl_wr & ~busy) begin
				op_r <= op_w;
				path_sel_r <= pwdata[`HBX_CTRL_PATH];
				ub_r <= pwdata[`HBX_CTRL_UB];
				lb_r <= pwdata[`HBX_CTRL_LB];
			end
			if (wr_stb & hit(paddr, `HBX_ADDR_WDATA) & ~busy) begin
				wdata_r <= pwdata[15:0];
			end
			// a finishing operation beats a clear in the same cycle
			done_r <= done_set | (done_r & ~done_clr);
			xchg_dir <= dir_nxt;
			xchg_path <= path_nxt;
			upper_byte_out_en_n <= uoe_nxt;
			lower_byte_out_en_n <= loe_nxt;
			latch_en_r <= latch_nxt;
			col_strobe_n <= cas_nxt;
			x_out <= wdata_r;
			x_oe <= xoe_nxt;
		end
	end

	// one shared enable so both read latches open and close together
	assign even_read_latch_enable = latch_en_r;
	assign odd_read_latch_enable = latch_en_r;
	// write latches left transparent
	assign even_write_latch_enable = 1'b1;
	assign odd_write_latch_enable = 1'b1;

endmodule // hbx_ctrl
`default_nettype wire

// ---- hw/hbx_defs.vh ----
`ifndef HBX_DEFS_VH
`define HBX_DEFS_VH
// Notes on behaviour
// - controller holds both write latch enables high at all times
// - one shared read latch enable drives both memory port read latches
// - path high selects even memory port, path low selects odd port
// - burst read captures memory data into latch, then enables latch onto processor
// - for reads controller drives direction low, sets path, uses latch enables
// - burst: read both banks, close latches, present even then odd back to back
// - during sequencing, precharge and reassert column strobe for next word pair
// - single reads keep latches open, exchanger acts as flow-through transceiver
// - writes: direction high, path selects target, bytes by enables, no latching

// register byte offsets
`define HBX_ADDR_CTRL 12'h000
`define HBX_ADDR_STATUS 12'h004
`define HBX_ADDR_WDATA 12'h008
`define HBX_ADDR_RDATA0 12'h010
`define HBX_ADDR_RDATA3 12'h01C

// control fields
`define HBX_CTRL_START 0
`define HBX_CTRL_OP_LO 1
`define HBX_CTRL_OP_HI 2
`define HBX_CTRL_PATH 3
`define HBX_CTRL_UB 4
`define HBX_CTRL_LB 5
`define HBX_CTRL_RST 32'h0000_0030

// operation codes
`define HBX_OP_SINGLE 2'h0
`define HBX_OP_BURST 2'h1
`define HBX_OP_WRITE 2'h2

// status fields
`define HBX_STAT_BUSY 0
`define HBX_STAT_DONE 1

// timing
`define HBX_CLK_PERIOD_NS 8
`define HBX_T_ACC_NS 40
`define HBX_T_WR_NS 40
`define HBX_T_ACC_CYC ((`HBX_T_ACC_NS + `HBX_CLK_PERIOD_NS - 1) / `HBX_CLK_PERIOD_NS)
`define HBX_T_WR_CYC ((`HBX_T_WR_NS + `HBX_CLK_PERIOD_NS - 1) / `HBX_CLK_PERIOD_NS)

`endif

// ---- hw/hbx_word_mem.v ----
`timescale 1ns/1ns
`default_nettype none
module hbx_word_mem #(
	parameter W = 16,
	parameter AW = 2
) (
	// clock
	input wire pclk,
	// write side
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [W-1:0] wdata,
	// read side
	input wire [AW-1:0] raddr,
	output reg [W-1:0] rdata_r
);

	reg [W-1:0] mem [0:(1<<AW)-1];

	// no reset on the array; software reads it only after a finished read
	always @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_r <= mem[raddr];
	end

endmodule // hbx_word_mem
`default_nettype wire

// ---- hw/hbx_apb_if.v ----
`timescale 1ns/1ns
`default_nettype none
module hbx_apb_if (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb request
	input wire psel,
	input wire penable,
	input wire pwrite,
	// answer sources
	input wire [31:0] rdata_in,
	input wire hit_in,
	// apb answer
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	// one-cycle write strobe at completion
	output wire wr_stb
);

	reg resp_r;

	// one wait state so prdata always comes out of a flop
	assign pready = psel & penable & resp_r;
	assign wr_stb = pready & pwrite & hit_in;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_r <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & penable & ~resp_r) begin
			resp_r <= 1'b1;
			prdata <= (hit_in & ~pwrite) ? rdata_in : 32'h0000_0000;
			pslverr <= ~hit_in;
		end else begin
			resp_r <= 1'b0;
		end
	end

endmodule // hbx_apb_if
`default_nettype wire

// ---- sim/hbx_ctrl_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbx_ctrl_sva (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// exchanger pins
	input wire xchg_dir,
	input wire xchg_path,
	input wire even_read_latch_enable,
	input wire odd_read_latch_enable,
	input wire even_write_latch_enable,
	input wire odd_write_latch_enable,
	input wire col_strobe_n,
	input wire x_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_wr_latch_open: assert property (even_write_latch_enable && odd_write_latch_enable)
		else $error("write latch enable low");
	a_rd_le_shared: assert property (even_read_latch_enable == odd_read_latch_enable)
		else $error("read latch enables differ");
	a_close_even: assert property ($fell(even_read_latch_enable) |-> xchg_path && !xchg_dir)
		else $error("latch closed without even read path");
	a_even_odd: assert property ($fell(even_read_latch_enable) |=> !xchg_path && !even_read_latch_enable)
		else $error("odd word not presented after even");
	a_latch_reopen: assert property ($fell(even_read_latch_enable) |-> ##2 even_read_latch_enable)
		else $error("read latch not reopened");
	a_cas_precharge: assert property ($fell(even_read_latch_enable) |-> $rose(col_strobe_n))
		else $error("no precharge at latch close");
	a_wr_dir: assert property (xchg_dir |-> x_oe && !col_strobe_n)
		else $error("write direction without drive");
	a_drive_write: assert property (x_oe |-> xchg_dir)
		else $error("processor drive during read");
endmodule // hbx_ctrl_sva
bind hbx_ctrl hbx_ctrl_sva u_sva (.*);
`default_nettype wire

// ---- sim/hbx_xchg_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbx_xchg_model #(
	parameter [15:0] EVEN_BASE = 16'h1000,
	parameter [15:0] ODD_BASE = 16'h2000
) (
	// control pins
	input wire xchg_dir,
	input wire xchg_path,
	input wire upper_byte_out_en_n,
	input wire lower_byte_out_en_n,
	input wire even_read_latch_enable,
	input wire odd_read_latch_enable,
	input wire even_write_latch_enable,
	input wire odd_write_latch_enable,
	input wire col_strobe_n,
	// processor port
	input wire [15:0] x_out,
	output logic [15:0] x_in,
	// memory ports
	output logic [15:0] even_dat,
	output logic [1:0] even_en,
	output logic [15:0] odd_dat,
	output logic [1:0] odd_en
);
	// each column strobe presents a fresh word pair
	integer pair_k = 0;
	logic [15:0] even_lat;
	logic [15:0] odd_lat;
	logic [15:0] sel;
	logic [15:0] en_mask;
	logic [15:0] even_wl;
	logic [15:0] odd_wl;
	always @(negedge col_strobe_n) pair_k = pair_k + 1;
	always @* if (even_read_latch_enable) even_lat = EVEN_BASE + pair_k[15:0];
	always @* if (odd_read_latch_enable) odd_lat = ODD_BASE + pair_k[15:0];
	always @* if (even_write_latch_enable) even_wl = x_out;
	always @* if (odd_write_latch_enable) odd_wl = x_out;
	assign en_mask = {{8{~upper_byte_out_en_n}}, {8{~lower_byte_out_en_n}}};
	// a memory port only carries write data where selected and enabled
	assign even_dat = even_wl ^ ~({16{xchg_dir & xchg_path}} & en_mask);
	assign odd_dat = odd_wl ^ ~({16{xchg_dir & ~xchg_path}} & en_mask);
	assign sel = xchg_path ? even_lat : odd_lat;
	// undriven bytes show the inverse so a stale value never passes
	assign x_in = xchg_dir ? ~x_out : sel ^ ~en_mask;
	assign even_en = {2{xchg_dir & xchg_path}} & ~{upper_byte_out_en_n, lower_byte_out_en_n};
	assign odd_en = {2{xchg_dir & ~xchg_path}} & ~{upper_byte_out_en_n, lower_byte_out_en_n};
endmodule // hbx_xchg_model
`default_nettype wire

// ---- sim/hbx_ctrl_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbx_ctrl_tb_top;
	localparam [15:0] EB = 16'h1000;
	localparam [15:0] OB = 16'h2000;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, xchg_dir, xchg_path, upper_byte_out_en_n, lower_byte_out_en_n, col_strobe_n, x_oe;
	wire even_read_latch_enable, odd_read_latch_enable, even_write_latch_enable, odd_write_latch_enable;
	wire [15:0] x_in, x_out, even_dat, odd_dat;
	wire [1:0] even_en, odd_en;
	integer err_count = 0, total_checks = 0;
	always #4 pclk = ~pclk;
	hbx_ctrl #(.ACC_CYC(8'd2), .WR_CYC(8'd2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .xchg_dir, .xchg_path, .upper_byte_out_en_n,
		.lower_byte_out_en_n, .even_read_latch_enable, .odd_read_latch_enable, .even_write_latch_enable,
		.odd_write_latch_enable, .col_strobe_n, .x_in, .x_out, .x_oe);
	hbx_xchg_model #(.EVEN_BASE(EB), .ODD_BASE(OB)) u_xm (.xchg_dir, .xchg_path, .upper_byte_out_en_n,
		.lower_byte_out_en_n, .even_read_latch_enable, .odd_read_latch_enable, .even_write_latch_enable,
		.odd_write_latch_enable, .col_strobe_n, .x_out, .x_in, .even_dat, .even_en, .odd_dat, .odd_en);
	////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// pready, prdata and pslverr are taken at the rising edge that completes the access
	task apb(input logic w, input [11:0] a, input [31:0] d);
		integer n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				err_count++;
				summarize;
			end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wait_done;
		integer n;
		n = 0;
		rd = 0;
		while (rd[1] !== 1'b1) begin
			apb(0, 12'h004, 0);
			n++;
			if (n > 30) begin
				err_count++;
				summarize;
			end
		end
		apb(1, 12'h004, 32'h0000_0002);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		apb(0, 12'h000, 0);
		chk("ctrl", 32'h0000_0030, rd);
		apb(0, 12'h004, 0);
		chk("status", 0, rd);
		apb(0, 12'h020, 0);
		chk("slverr", 1, {31'h0, er});
		chk("unmapped", 0, rd);
		chk("idle_pins", {25'h0, 7'b0011110}, {25'h0, xchg_dir, xchg_path, upper_byte_out_en_n, lower_byte_out_en_n,
			even_read_latch_enable, col_strobe_n, x_oe});
	endtask
	task t_single(input logic p, input logic u, input logic l);
		integer k;
		logic [15:0] w;
		k = u_xm.pair_k + 1;
		w = (p ? EB : OB) + k[15:0];
		apb(1, 12'h000, {26'h0, l, u, p, 2'h0, 1'b1});
		wait_done;
		apb(0, 12'h010, 0);
		chk("single", {16'h0, w ^ ~{{8{u}}, {8{l}}}}, rd);
	endtask
	task t_burst;
		integer k, i;
		k = u_xm.pair_k;
		apb(1, 12'h000, 32'h0000_0033);
		wait_done;
		for (i = 0; i < 4; i++) begin
			apb(0, 12'h010 + 12'(4 * i), 0);
			chk("burst", {16'h0, (i[0] ? OB : EB) + 16'(k + 1 + i / 2)}, rd);
		end
	endtask
	task t_write(input logic p, input logic u, input logic l, input [15:0] d);
		integer n;
		apb(1, 12'h008, {16'h0, d});
		apb(1, 12'h000, {26'h0, l, u, p, 2'h2, 1'b1});
		n = 0;
		while (x_oe !== 1'b1) begin
			@(negedge pclk);
			n++;
			if (n > 20) begin
				err_count++;
				summarize;
			end
		end
		chk("wr_data", {16'h0, d ^ ~{{8{u}}, {8{l}}}}, {16'h0, p ? even_dat : odd_dat});
		chk("wr_quiet", {16'h0, ~d}, {16'h0, p ? odd_dat : even_dat});
		chk("wr_en", {30'h0, u, l}, {30'h0, p ? even_en : odd_en});
		chk("wr_other", 0, {30'h0, p ? odd_en : even_en});
		wait_done;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_single(1, 1, 1);
		t_single(0, 1, 1);
		t_single(1, 1, 0);
		t_single(0, 0, 1);
		t_single(1, 0, 0);
		t_burst;
		t_burst;
		t_write(1, 1, 1, 16'ha5c3);
		t_write(0, 0, 1, 16'h5a3c);
		summarize;
	end
endmodule // hbx_ctrl_tb_top
`default_nettype wire
